// ==== hw/swlc_top.sv ====
// Swing frequency generator, fixed length unit and pulse counter.
// Operation
// - Swing the output frequency around the centre frequency while enabled.
// - Zero swing percentage gives no swing; output stays at centre.
// - Base select 0: amplitude is centre frequency times swing percentage.
// - Base select 1: amplitude is maximum frequency times swing percentage.
// - Jump step is amplitude times jump percentage, up to 50.0%.
// - Swinging frequency is clamped between upper and lower limit.
// - One full swing period lasts the cycle time, default 10.0 s.
// - Rise lasts cycle times coefficient, fall lasts the remainder.
// - Measured length is ten times pulse count divided by pulses per metre.
// - Length reached output turns on when length exceeds target.
// - Length reset input clears the length measurement.
// - Length pulses come on the fast pulse input.
// - Event counter counts pulses on the counter input.
// - At final threshold, final output turns on and counting halts.
// - At intermediate threshold, its output turns on; counting goes on.
`timescale 1ns/1ps
`default_nettype none
module swlc_top #(
  parameter int unsigned TickCycles = swlc_pkg::TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic fastPulseInput,
  input wire logic lenResetIn,
  input wire logic countPulseIn,
  output logic [31:0] rdData,
  output logic [15:0] outFreq,
  output logic lengthReached,
  output logic finalReached,
  output logic interReached,
  output logic irq
);
  localparam int DW = 40;

  logic swingEnable_q;
  logic swingBaseSelect_q;
  logic [15:0] swingAmplitudePct_q;
  logic [15:0] jumpAmplitudePct_q;
  logic [15:0] swingCycleTime_q;
  logic [15:0] riseTimeCoeff_q;
  logic [15:0] centreFreq_q;
  logic [15:0] maxOutputFreq_q;
  logic [15:0] upperLimit_q;
  logic [15:0] lowerLimit_q;
  logic [15:0] targetLength_q;
  logic [15:0] pulsesPerMetre_q;
  logic [15:0] finalCountThreshold_q;
  logic [15:0] intermediateCountThreshold_q;
  logic [2:0] irqEnable_q;
  logic [2:0] status_q;
  logic [2:0] statusEvt;
  logic countClear;

  // Saturating store keeps the swing, jump, cycle time and rise settings inside their legal ranges.
  function automatic logic [15:0] sat16(input logic [31:0] v,
                                        input logic [15:0] lim);
    sat16 = (v > {16'h0000, lim}) ? lim : v[15:0];
  endfunction

  // Scales a value by a percentage held in tenths of a percent.
  function automatic logic [15:0] pctOf(input logic [15:0] base,
                                        input logic [15:0] pct);
    logic [31:0] prod;
    prod = 32'(base) * 32'(pct);
    pctOf = 16'(prod / swlc_pkg::PCT_FULL);
  endfunction

  assign countClear = wrEn && (addr == swlc_pkg::ADDR_CTRL) &&
                      wrData[swlc_pkg::CTRL_COUNT_CLR];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      swingEnable_q <= 1'b0;
      swingBaseSelect_q <= 1'b0;
      swingAmplitudePct_q <= 16'h0000;
      jumpAmplitudePct_q <= 16'h0000;
      swingCycleTime_q <= swlc_pkg::RST_CYCLE_TIME;
      riseTimeCoeff_q <= swlc_pkg::RST_RISE_COEFF;
      centreFreq_q <= 16'h0000;
      maxOutputFreq_q <= swlc_pkg::RST_MAX_FREQ;
      upperLimit_q <= swlc_pkg::RST_UPPER_LIMIT;
      lowerLimit_q <= 16'h0000;
      targetLength_q <= swlc_pkg::RST_TARGET_LEN;
      pulsesPerMetre_q <= swlc_pkg::RST_PULSES_PER_M;
      finalCountThreshold_q <= swlc_pkg::RST_FINAL_THR;
      intermediateCountThreshold_q <= swlc_pkg::RST_INTER_THR;
      irqEnable_q <= 3'h0;
    end else if (wrEn) begin
      case (addr)
        swlc_pkg::ADDR_CTRL: begin
          swingEnable_q <= wrData[swlc_pkg::CTRL_SWING_EN];
          swingBaseSelect_q <= wrData[swlc_pkg::CTRL_BASE_SEL];
        end
        swlc_pkg::ADDR_SWING_PCT:
          swingAmplitudePct_q <= sat16(wrData, swlc_pkg::SWING_PCT_MAX);
        swlc_pkg::ADDR_JUMP_PCT:
          jumpAmplitudePct_q <= sat16(wrData, swlc_pkg::JUMP_PCT_MAX);
        swlc_pkg::ADDR_CYCLE_TIME:
          swingCycleTime_q <= sat16(wrData, swlc_pkg::CYCLE_TIME_MAX);
        swlc_pkg::ADDR_RISE_COEFF:
          riseTimeCoeff_q <= sat16(wrData, swlc_pkg::RISE_COEFF_MAX);
        swlc_pkg::ADDR_CENTRE_FREQ: centreFreq_q <= wrData[15:0];
        swlc_pkg::ADDR_MAX_FREQ: maxOutputFreq_q <= wrData[15:0];
        swlc_pkg::ADDR_UPPER_LIMIT: upperLimit_q <= wrData[15:0];
        swlc_pkg::ADDR_LOWER_LIMIT: lowerLimit_q <= wrData[15:0];
        swlc_pkg::ADDR_TARGET_LEN: targetLength_q <= wrData[15:0];
        swlc_pkg::ADDR_PULSES_PER_M: begin
          // Zero pulses per metre would divide by zero, so it becomes one.
          pulsesPerMetre_q <= (wrData[15:0] == 16'h0000) ? 16'h0001 :
                              wrData[15:0];
        end
        swlc_pkg::ADDR_FINAL_THR:
          finalCountThreshold_q <= (wrData[15:0] == 16'h0000) ? 16'h0001 :
                                   wrData[15:0];
        swlc_pkg::ADDR_INTER_THR:
          intermediateCountThreshold_q <= (wrData[15:0] == 16'h0000) ?
                                          16'h0001 : wrData[15:0];
        swlc_pkg::ADDR_IRQ_EN: irqEnable_q <= wrData[2:0];
        default: ;
      endcase
    end
  end

  // Swing generator.
  logic [31:0] tickCnt_q;
  logic tick_q;
  logic swingOn;
  logic [15:0] swingSpan;
  logic [15:0] jumpStep;
  logic [31:0] totalTicks;
  logic [31:0] riseTicks;
  logic [31:0] fallTicks;
  logic [31:0] phaseTicks;
  logic [31:0] step_q;
  logic [16:0] rampSpan;
  logic swStart_q;
  logic swBusy;
  logic swDone;
  logic [DW-1:0] swQuo;
  logic [DW-1:0] swNum;
  logic [DW-1:0] swDen;
  logic signed [18:0] rampFreq;
  logic [15:0] outFreq_q;
  swlc_pkg::swlc_phase_t phase_q;

  assign swingOn = swingEnable_q && (swingAmplitudePct_q != 16'h0000);

  always_comb begin
    if (swingBaseSelect_q) begin
      swingSpan = pctOf(maxOutputFreq_q, swingAmplitudePct_q);
    end else begin
      swingSpan = pctOf(centreFreq_q, swingAmplitudePct_q);
    end
  end

  assign jumpStep = pctOf(swingSpan, jumpAmplitudePct_q);
  assign totalTicks = 32'(swingCycleTime_q) * swlc_pkg::TICKS_PER_TENTH_S;
  assign riseTicks = (totalTicks * 32'(riseTimeCoeff_q)) / swlc_pkg::PCT_FULL;
  assign fallTicks = totalTicks - riseTicks;
  assign phaseTicks = (phase_q == swlc_pkg::SW_FALL) ? fallTicks : riseTicks;
  assign rampSpan = {swingSpan, 1'b0} - {1'b0, jumpStep};
  assign swNum = DW'(rampSpan) * DW'(step_q);
  assign swDen = (phaseTicks == 32'h00000000) ? DW'(1) : DW'(phaseTicks);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tickCnt_q <= 32'h00000000;
      tick_q <= 1'b0;
    end else if (tickCnt_q >= TickCycles - 1) begin
      tickCnt_q <= 32'h00000000;
      tick_q <= 1'b1;
    end else begin
      tickCnt_q <= tickCnt_q + 32'h00000001;
      tick_q <= 1'b0;
    end
  end

  // A phase change moves the start point by the jump step.
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !swingOn) begin
      phase_q <= swlc_pkg::SW_IDLE;
      step_q <= 32'h00000000;
    end else if (tick_q) begin
      case (phase_q)
        swlc_pkg::SW_IDLE: begin
          phase_q <= swlc_pkg::SW_RISE;
          step_q <= 32'h00000000;
        end
        swlc_pkg::SW_RISE: begin
          if (step_q + 32'h00000001 >= riseTicks) begin
            phase_q <= swlc_pkg::SW_FALL;
            step_q <= 32'h00000000;
          end else begin
            step_q <= step_q + 32'h00000001;
          end
        end
        swlc_pkg::SW_FALL: begin
          if (step_q + 32'h00000001 >= fallTicks) begin
            phase_q <= swlc_pkg::SW_RISE;
            step_q <= 32'h00000000;
          end else begin
            step_q <= step_q + 32'h00000001;
          end
        end
        default: phase_q <= swlc_pkg::SW_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      swStart_q <= 1'b0;
    end else begin
      swStart_q <= tick_q & swingOn;
    end
  end

  swlc_div #(.W(DW)) swingDiv (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(swStart_q),
    .num(swNum),
    .den(swDen),
    .busy(swBusy),
    .done(swDone),
    .quo(swQuo)
  );

  always_comb begin
    if (phase_q == swlc_pkg::SW_FALL) begin
      rampFreq = $signed({3'b000, centreFreq_q}) + $signed({3'b000, swingSpan}) -
                 $signed({3'b000, jumpStep}) - $signed({2'b00, swQuo[16:0]});
    end else begin
      rampFreq = $signed({3'b000, centreFreq_q}) - $signed({3'b000, swingSpan}) +
                 $signed({3'b000, jumpStep}) + $signed({2'b00, swQuo[16:0]});
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      outFreq_q <= 16'h0000;
    end else if (!swingOn) begin
      outFreq_q <= centreFreq_q;
    end else if (swDone) begin
      if (rampFreq > $signed({3'b000, upperLimit_q})) begin
        outFreq_q <= upperLimit_q;
      end else if (rampFreq < $signed({3'b000, lowerLimit_q})) begin
        outFreq_q <= lowerLimit_q;
      end else begin
        outFreq_q <= rampFreq[15:0];
      end
    end
  end

  // Fixed length unit.
  logic lenRise;
  logic [31:0] lenPulses_q;
  logic lenStale_q;
  logic lenBusy;
  logic lenDone;
  logic [DW-1:0] lenQuo;
  logic [15:0] measuredLength_q;
  logic lengthReached_q;
  logic lenReachD;

  swlc_edge lenEdge (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .level(fastPulseInput),
    .rise(lenRise)
  );

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lenPulses_q <= 32'h00000000;
    end else if (lenResetIn) begin
      lenPulses_q <= 32'h00000000;
    end else if (lenRise && lenPulses_q != 32'hFFFFFFFF) begin
      lenPulses_q <= lenPulses_q + 32'h00000001;
    end
  end

  // A quotient started before a length reset is thrown away.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lenStale_q <= 1'b0;
    end else if (lenResetIn) begin
      lenStale_q <= 1'b1;
    end else if (!lenBusy) begin
      lenStale_q <= 1'b0;
    end
  end

  swlc_div #(.W(DW)) lengthDiv (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(!lenBusy && !lenResetIn),
    .num(DW'(lenPulses_q) * DW'(swlc_pkg::LENGTH_SCALE)),
    .den(DW'(pulsesPerMetre_q)),
    .busy(lenBusy),
    .done(lenDone),
    .quo(lenQuo)
  );

  always_ff @(posedge ref_clk) begin
    if (!rst_n || lenResetIn) begin
      measuredLength_q <= 16'h0000;
    end else if (lenDone && !lenStale_q) begin
      measuredLength_q <= (lenQuo > DW'(16'hFFFF)) ? 16'hFFFF :
                          lenQuo[15:0];
    end
  end

  assign lenReachD = !lenResetIn && (measuredLength_q > targetLength_q);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lengthReached_q <= 1'b0;
    end else begin
      lengthReached_q <= lenReachD;
    end
  end

  // Pulse counter.
  logic cntRise;
  logic [15:0] count_q;
  logic finalReached_q;
  logic interReached_q;
  logic finReachD;
  logic intReachD;

  swlc_edge countEdge (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .level(countPulseIn),
    .rise(cntRise)
  );

  always_ff @(posedge ref_clk) begin
    if (!rst_n || countClear) begin
      count_q <= 16'h0000;
    end else if (cntRise && count_q < finalCountThreshold_q) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // A lowered final threshold also stops the count at once.
  assign finReachD = count_q >= finalCountThreshold_q;
  assign intReachD = count_q >= intermediateCountThreshold_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      finalReached_q <= 1'b0;
      interReached_q <= 1'b0;
    end else begin
      finalReached_q <= finReachD;
      interReached_q <= intReachD;
    end
  end

  // Status, interrupt and read port.
  logic [31:0] rdData_q;
  logic irq_q;
  logic [2:0] statusClr;

  assign statusEvt = {intReachD & ~interReached_q,
                      finReachD & ~finalReached_q,
                      lenReachD & ~lengthReached_q};
  assign statusClr = (wrEn && addr == swlc_pkg::ADDR_STATUS_CLR) ?
                     wrData[2:0] : 3'h0;

  // A new event wins over a clear written in the same cycle.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      status_q <= 3'h0;
      irq_q <= 1'b0;
    end else begin
      status_q <= (status_q & ~statusClr) | statusEvt;
      irq_q <= |(((status_q & ~statusClr) | statusEvt) & irqEnable_q);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdData_q <= 32'h00000000;
    end else if (rdEn) begin
      case (addr)
        swlc_pkg::ADDR_CTRL:
          rdData_q <= {30'h00000000, swingBaseSelect_q, swingEnable_q};
        swlc_pkg::ADDR_SWING_PCT: rdData_q <= {16'h0000, swingAmplitudePct_q};
        swlc_pkg::ADDR_JUMP_PCT: rdData_q <= {16'h0000, jumpAmplitudePct_q};
        swlc_pkg::ADDR_CYCLE_TIME: rdData_q <= {16'h0000, swingCycleTime_q};
        swlc_pkg::ADDR_RISE_COEFF: rdData_q <= {16'h0000, riseTimeCoeff_q};
        swlc_pkg::ADDR_CENTRE_FREQ: rdData_q <= {16'h0000, centreFreq_q};
        swlc_pkg::ADDR_MAX_FREQ: rdData_q <= {16'h0000, maxOutputFreq_q};
        swlc_pkg::ADDR_UPPER_LIMIT: rdData_q <= {16'h0000, upperLimit_q};
        swlc_pkg::ADDR_LOWER_LIMIT: rdData_q <= {16'h0000, lowerLimit_q};
        swlc_pkg::ADDR_TARGET_LEN: rdData_q <= {16'h0000, targetLength_q};
        swlc_pkg::ADDR_PULSES_PER_M: rdData_q <= {16'h0000, pulsesPerMetre_q};
        swlc_pkg::ADDR_FINAL_THR:
          rdData_q <= {16'h0000, finalCountThreshold_q};
        swlc_pkg::ADDR_INTER_THR:
          rdData_q <= {16'h0000, intermediateCountThreshold_q};
        swlc_pkg::ADDR_OUT_FREQ: rdData_q <= {16'h0000, outFreq_q};
        swlc_pkg::ADDR_MEAS_LEN: rdData_q <= {16'h0000, measuredLength_q};
        swlc_pkg::ADDR_COUNT: rdData_q <= {16'h0000, count_q};
        swlc_pkg::ADDR_STATUS: rdData_q <= {29'h00000000, status_q};
        swlc_pkg::ADDR_IRQ_EN: rdData_q <= {29'h00000000, irqEnable_q};
        default: rdData_q <= 32'h00000000;
      endcase
    end else begin
      rdData_q <= 32'h00000000;
    end
  end

  assign rdData = rdData_q;
  assign outFreq = outFreq_q;
  assign lengthReached = lengthReached_q;
  assign finalReached = finalReached_q;
  assign interReached = interReached_q;
  assign irq = irq_q;
endmodule // swlc_top
`default_nettype wire

// ==== hw/swlc_pkg.sv ====
// Shared constants of the swing, length and count block.
package swlc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TICK_TIME_US = 1000;
  localparam int unsigned TICK_CYCLES = TICK_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned TICKS_PER_TENTH_S = 100000 / TICK_TIME_US;
  localparam logic [31:0] PCT_FULL = 32'h000003E8;
  localparam logic [15:0] SWING_PCT_MAX = 16'h03E8;
  localparam logic [15:0] JUMP_PCT_MAX = 16'h01F4;
  localparam logic [15:0] CYCLE_TIME_MAX = 16'h7530;
  localparam logic [15:0] RISE_COEFF_MAX = 16'h03E8;
  localparam logic [15:0] LENGTH_SCALE = 16'h000A;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SWING_PCT = 8'h04;
  localparam logic [7:0] ADDR_JUMP_PCT = 8'h08;
  localparam logic [7:0] ADDR_CYCLE_TIME = 8'h0C;
  localparam logic [7:0] ADDR_RISE_COEFF = 8'h10;
  localparam logic [7:0] ADDR_CENTRE_FREQ = 8'h14;
  localparam logic [7:0] ADDR_MAX_FREQ = 8'h18;
  localparam logic [7:0] ADDR_UPPER_LIMIT = 8'h1C;
  localparam logic [7:0] ADDR_LOWER_LIMIT = 8'h20;
  localparam logic [7:0] ADDR_TARGET_LEN = 8'h24;
  localparam logic [7:0] ADDR_PULSES_PER_M = 8'h28;
  localparam logic [7:0] ADDR_FINAL_THR = 8'h2C;
  localparam logic [7:0] ADDR_INTER_THR = 8'h30;
  localparam logic [7:0] ADDR_OUT_FREQ = 8'h34;
  localparam logic [7:0] ADDR_MEAS_LEN = 8'h38;
  localparam logic [7:0] ADDR_COUNT = 8'h3C;
  localparam logic [7:0] ADDR_STATUS = 8'h40;
  localparam logic [7:0] ADDR_STATUS_CLR = 8'h44;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h48;

  localparam int unsigned CTRL_SWING_EN = 0;
  localparam int unsigned CTRL_BASE_SEL = 1;
  localparam int unsigned CTRL_COUNT_CLR = 2;
  localparam int unsigned ST_LENGTH = 0;
  localparam int unsigned ST_FINAL = 1;
  localparam int unsigned ST_INTER = 2;

  localparam logic [15:0] RST_CYCLE_TIME = 16'h0064;
  localparam logic [15:0] RST_RISE_COEFF = 16'h01F4;
  localparam logic [15:0] RST_TARGET_LEN = 16'h03E8;
  localparam logic [15:0] RST_PULSES_PER_M = 16'h03E8;
  localparam logic [15:0] RST_FINAL_THR = 16'h03E8;
  localparam logic [15:0] RST_INTER_THR = 16'h03E8;
  localparam logic [15:0] RST_UPPER_LIMIT = 16'hFFFF;
  localparam logic [15:0] RST_MAX_FREQ = 16'h1388;

  typedef enum logic [1:0] {SW_IDLE, SW_RISE, SW_FALL} swlc_phase_t;
endpackage

// ==== hw/swlc_div.sv ====
// Sequential restoring divider, one quotient bit per clock.
`timescale 1ns/1ps
`default_nettype none
module swlc_div #(
  parameter int W = 40
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [W-1:0] num,
  input wire logic [W-1:0] den,
  output logic busy,
  output logic done,
  output logic [W-1:0] quo
);
  logic [W-1:0] rem_q;
  logic [W-1:0] den_q;
  logic [$clog2(W+1)-1:0] cnt_q;
  logic [W:0] trial;
  logic fits;

  assign trial = {rem_q, quo[W-1]};
  assign fits = trial >= {1'b0, den_q};

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rem_q <= '0;
      den_q <= '0;
      quo <= '0;
      cnt_q <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        rem_q <= '0;
        den_q <= den;
        quo <= num;
        cnt_q <= ($clog2(W+1))'(W);
        busy <= 1'b1;
      end else if (busy) begin
        rem_q <= fits ? W'(trial - {1'b0, den_q}) : trial[W-1:0];
        quo <= {quo[W-2:0], fits};
        cnt_q <= cnt_q - 1'b1;
        if (cnt_q == 1) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule // swlc_div
`default_nettype wire

// ==== hw/swlc_edge.sv ====
// Rising edge detector for a terminal input, registered output.
`timescale 1ns/1ps
`default_nettype none
module swlc_edge (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic level,
  output logic rise
);
  logic prev_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
      rise <= 1'b0;
    end else begin
      prev_q <= level;
      rise <= level & ~prev_q;
    end
  end
endmodule // swlc_edge
`default_nettype wire

// ==== verif/swlc_monitor.sv ====
// Port checks for the swing, length and count block.
`timescale 1ns/1ps
`default_nettype none
module swlc_monitor (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic lenResetIn,
  input wire logic countPulseIn,
  input wire logic [31:0] rdData,
  input wire logic [15:0] outFreq,
  input wire logic lengthReached,
  input wire logic finalReached,
  input wire logic interReached,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_read_idle_zero: assert property (!$past(rdEn) |-> rdData == 32'h0)
    else $error("read data outside read slot");
  a_clr_reads_zero: assert property ($past(rdEn) &&
    $past(addr) == swlc_pkg::ADDR_STATUS_CLR |-> rdData == 32'h0)
    else $error("status clear read not zero");
  a_reset_quiet: assert property ($rose(rst_n) |-> !irq && !finalReached &&
    !interReached && !lengthReached && outFreq == 16'h0000)
    else $error("outputs not cleared by reset");
  // A clear or a new threshold shows on the flag two edges after its write.
  a_final_holds: assert property (finalReached && !$past(wrEn) |=> finalReached)
    else $error("final flag dropped");
  a_inter_holds: assert property (interReached && !$past(wrEn) |=> interReached)
    else $error("intermediate flag dropped");
  a_inter_cause: assert property ($rose(interReached) |->
    $past(countPulseIn, 3) || $past(wrEn, 2))
    else $error("intermediate flag without cause");
  a_len_clear: assert property (lenResetIn ##1 lenResetIn |-> !lengthReached)
    else $error("length flag kept during clear");
  a_irq_cause: assert property ($rose(irq) |-> lengthReached ||
    finalReached || interReached || $past(wrEn, 2))
    else $error("interrupt without event");
  a_irq_clear: assert property (wrEn && wrData[2:0] == 3'h7 &&
    addr == swlc_pkg::ADDR_STATUS_CLR |-> ##2 !irq)
    else $error("interrupt not cleared");
endmodule // swlc_monitor
`default_nettype wire

// ==== verif/swlc_pulse_src.sv ====
// Pulse sources on the digital input terminals of the block.
`timescale 1ns/1ps
`default_nettype none
module swlc_pulse_src (
  input wire logic ref_clk,
  output logic lenPulse,
  output logic cntPulse,
  output logic lenClr
);
  logic [2:0] lvl = 3'h0;
  assign lenPulse = lvl[0];
  assign cntPulse = lvl[1];
  assign lenClr = lvl[2];
  // Two cycles per level, so no edge can slip between samples.
  task automatic pulses(input int s, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      lvl[s] <= 1'b1;
      repeat (2) @(posedge ref_clk);
      lvl[s] <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
endmodule // swlc_pulse_src
`default_nettype wire

// ==== verif/test_swlc_top.sv ====
// Self-checking bench for the swing, length and count block.
`timescale 1ns/1ps
`default_nettype none
module test_swlc_top;
  logic ref_clk, rst_n, wrEn, rdEn, lenPulse, cntPulse, lenClr;
  logic [7:0] addr;
  logic [31:0] wrData, rdData, rv;
  logic [15:0] outFreq, lo, hi;
  logic lengthReached, finalReached, interReached, irq;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  localparam logic [7:0] RA [8] = '{8'h0C, 8'h10, 8'h24, 8'h28, 8'h2C,
    8'h1C, 8'h18, 8'h4C};
  localparam logic [15:0] RV [8] = '{16'h0064, 16'h01F4, 16'h03E8,
    16'h03E8, 16'h03E8, 16'hFFFF, 16'h1388, 16'h0000};
  swlc_top #(.TickCycles(64)) i_swlc_top (.ref_clk(ref_clk), .rst_n(rst_n),
    .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
    .fastPulseInput(lenPulse), .lenResetIn(lenClr), .countPulseIn(cntPulse),
    .rdData(rdData), .outFreq(outFreq), .lengthReached(lengthReached),
    .finalReached(finalReached), .interReached(interReached), .irq(irq));
  swlc_pulse_src i_swlc_pulse_src (.ref_clk(ref_clk), .lenPulse(lenPulse),
    .cntPulse(cntPulse), .lenClr(lenClr));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge ref_clk);
    wrEn <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge ref_clk);
    rdEn <= 1'b0;
    #1 rv = rdData;
    chk($sformatf("reg %h", a), e, rv);
  endtask
  // Waits past two divider runs so outputs have settled before sampling.
  task automatic sweep(input logic [15:0] el, input logic [15:0] eh);
    repeat (200) @(posedge ref_clk);
    lo = 16'hFFFF;
    hi = 16'h0000;
    repeat (7000) begin
      @(posedge ref_clk);
      if (outFreq < lo) lo = outFreq;
      if (outFreq > hi) hi = outFreq;
    end
    chk("swing low", el, lo);
    chk("swing high", eh, hi);
  endtask
  initial begin
    rst_n = 1'b0;
    wrEn = 1'b0;
    rdEn = 1'b0;
    addr = 8'h00;
    wrData = 32'h0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rc(RA[i], {16'h0, RV[i]});
    rc(8'h3C, 32'h0);
    wr(8'h08, 32'h03E8);
    rc(8'h08, 32'h01F4);
    wr(8'h2C, 32'h5);
    wr(8'h30, 32'h3);
    wr(8'h48, 32'h7);
    i_swlc_pulse_src.pulses(1, 3);
    repeat (6) @(posedge ref_clk);
    chk("inter", 32'h1, {31'h0, interReached});
    chk("final", 32'h0, {31'h0, finalReached});
    i_swlc_pulse_src.pulses(1, 4);
    repeat (6) @(posedge ref_clk);
    rc(8'h3C, 32'h5);
    chk("final", 32'h1, {31'h0, finalReached});
    chk("irq", 32'h1, {31'h0, irq});
    rc(8'h40, 32'h6);
    wr(8'h44, 32'h7);
    rc(8'h44, 32'h0);
    wr(8'h48, 32'h6);
    rc(8'h40, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    wr(8'h00, 32'h4);
    repeat (4) @(posedge ref_clk);
    chk("final", 32'h0, {31'h0, finalReached});
    wr(8'h28, 32'hA);
    wr(8'h24, 32'h2);
    i_swlc_pulse_src.pulses(0, 2);
    repeat (100) @(posedge ref_clk);
    chk("length", 32'h0, {31'h0, lengthReached});
    i_swlc_pulse_src.pulses(0, 1);
    repeat (100) @(posedge ref_clk);
    rc(8'h38, 32'h3);
    chk("length", 32'h1, {31'h0, lengthReached});
    chk("irq", 32'h0, {31'h0, irq});
    rc(8'h40, 32'h1);
    i_swlc_pulse_src.pulses(2, 1);
    repeat (100) @(posedge ref_clk);
    rc(8'h38, 32'h0);
    chk("length", 32'h0, {31'h0, lengthReached});
    wr(8'h14, 32'h03E8);
    wr(8'h0C, 32'h1);
    wr(8'h08, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h1);
    sweep(16'h03E8, 16'h03E8);
    wr(8'h04, 32'h64);
    sweep(16'h0384, 16'h044C);
    wr(8'h08, 32'h01F4);
    sweep(16'h0387, 16'h0449);
    wr(8'h08, 32'h0);
    wr(8'h04, 32'hA);
    wr(8'h00, 32'h3);
    sweep(16'h03B6, 16'h041A);
    wr(8'h04, 32'h64);
    wr(8'h00, 32'h1);
    wr(8'h20, 32'h03C0);
    wr(8'h1C, 32'h041A);
    sweep(16'h03C0, 16'h041A);
    end_of_test();
  end
endmodule // test_swlc_top
bind swlc_top swlc_monitor i_swlc_monitor (.ref_clk(ref_clk), .rst_n(rst_n),
  .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
  .lenResetIn(lenResetIn), .countPulseIn(countPulseIn), .rdData(rdData),
  .outFreq(outFreq), .lengthReached(lengthReached),
  .finalReached(finalReached), .interReached(interReached), .irq(irq));
`default_nettype wire
